// *** core/clock_ctrl_write_protect.sv ***
/*
 * Write protection, fault clear, violation status and RC trim override
 * for the clock controller register interface.
 * Assumes a single-cycle register port master on clk, a fault input from
 * the clock failure detector that may be asynchronous, and external
 * clock configuration registers that take writes from extWr.
 */
`timescale 1ns/1ns
module clock_ctrl_write_protect (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire clk_wp_pkg::word_type regAddr,
    input  wire clk_wp_pkg::word_type regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output clk_wp_pkg::word_type      regRdata,
    // Clock failure detector
    input  wire logic                 faultDetect,
    output logic                      faultOut,
    // Forwarded writes to shielded registers
    output logic                      extWr,
    output clk_wp_pkg::word_type      extAddr,
    output clk_wp_pkg::word_type      extWdata,
    // Trim
    input  wire clk_wp_pkg::trim_type flashTrimLow,
    input  wire clk_wp_pkg::trim_type flashTrimMid,
    input  wire clk_wp_pkg::trim_type flashTrimHigh,
    output clk_wp_pkg::trim_type      trimLow,
    output clk_wp_pkg::trim_type      trimMid,
    output clk_wp_pkg::trim_type      trimHigh,
    output logic                      protectOn,
    // Interrupt
    output logic                      irq
);
    import clk_wp_pkg::*;

    // *************************************************************
    // State
    // *************************************************************
    typedef struct packed {
        logic        protEn;
        logic        violFlag;
        logic [15:0] violSrc;
        word_type    cal;
        logic        faultLatch;
        logic        faultSyncA;
        logic        faultSyncB;
        logic        faultPrev;
        logic [1:0]  irqStat;
        logic [1:0]  irqMask;
        logic        irqLine;
        word_type    rdata;
        logic        extWr;
        word_type    extAddr;
        word_type    extWdata;
    } bank_state_type;

    localparam bank_state_type STATE_RESET = '{
        protEn:     PROTECT_RESET,
        violFlag:   1'b0,
        violSrc:    16'h0000,
        cal:        CAL_RESET,
        faultLatch: 1'b0,
        faultSyncA: 1'b0,
        faultSyncB: 1'b0,
        faultPrev:  1'b0,
        irqStat:    2'h0,
        irqMask:    2'h0,
        irqLine:    1'b0,
        rdata:      32'h00000000,
        extWr:      1'b0,
        extAddr:    32'h00000000,
        extWdata:   32'h00000000
    };

    bank_state_type s_q;
    bank_state_type s_d;

    // *************************************************************
    // Decoding
    // *************************************************************
    // shielded address set
    function automatic logic isShielded(input word_type addr);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < SHIELD_COUNT; i++) begin
            if (addr == SHIELD_ADDR[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : isShielded

    // Unmapped and write-only addresses read as zero
    function automatic word_type readValue(input word_type addr,
                                           input bank_state_type st);
        word_type v;
        v = 32'h00000000;
        unique case (addr)
            PROTECT_MODE_ADDR: begin
                v[PROTECT_EN_BIT] = st.protEn;
            end
            PROTECT_STAT_ADDR: begin
                v[VIOL_FLAG_BIT] = st.violFlag;
                v[VIOL_SRC_LSB +: 16] = st.violSrc;
            end
            OSC_CAL_ADDR: begin
                v = st.cal;
            end
            MAIN_STATUS_ADDR: begin
                v[FAULT_STATE_BIT] = st.faultLatch;
            end
            IRQ_STATUS_ADDR: begin
                v[1:0] = st.irqStat;
            end
            IRQ_MASK_ADDR: begin
                v[1:0] = st.irqMask;
            end
            default: begin
                v = 32'h00000000;
            end
        endcase
        return v;
    endfunction : readValue

    // *************************************************************
    // Next state
    // *************************************************************
    logic violation;
    logic faultRise;

    always_comb begin
        s_d       = s_q;
        violation = 1'b0;
        s_d.extWr = 1'b0;
        s_d.rdata = 32'h00000000;

        // Two-stage synchroniser; only the second stage feeds logic
        s_d.faultSyncA = faultDetect;
        s_d.faultSyncB = s_q.faultSyncA;
        s_d.faultPrev  = s_q.faultSyncB;
        faultRise      = s_q.faultSyncB & ~s_q.faultPrev;

        // Read data stands only in the cycle after the strobe
        if (regRd) begin
            s_d.rdata = readValue(regAddr, s_q);
            if (regAddr == PROTECT_STAT_ADDR) begin
                s_d.violFlag = 1'b0;
                s_d.violSrc  = 16'h0000;
            end
        end

        if (regWr) begin
            unique case (regAddr)
                FAULT_CLEAR_ADDR: begin
                    if (regWdata[FAULT_CLEAR_BIT]) begin
                        s_d.faultLatch = 1'b0;
                    end
                end
                PROTECT_MODE_ADDR: begin
                    if (regWdata[KEY_LSB +: 24] == KEY_PASSWORD) begin
                        s_d.protEn = regWdata[PROTECT_EN_BIT];
                    end
                    // wrong key leaves protEn as it was
                end
                OSC_CAL_ADDR: begin
                    if (!s_q.protEn) begin
                        s_d.cal = regWdata & CAL_MASK;
                    end else begin
                        violation = 1'b1;
                    end
                end
                IRQ_STATUS_ADDR: begin
                    s_d.irqStat = s_q.irqStat & ~regWdata[1:0];
                end
                IRQ_MASK_ADDR: begin
                    s_d.irqMask = regWdata[1:0] & IRQ_MASK_BITS;
                end
                default: begin
                    if (isShielded(regAddr)) begin
                        if (s_q.protEn) begin
                            violation = 1'b1;
                        end else begin
                            s_d.extWr    = 1'b1;
                            s_d.extAddr  = regAddr;
                            s_d.extWdata = regWdata;
                        end
                    end
                end
            endcase
        end

        if (violation) begin
            s_d.violFlag = 1'b1;
            s_d.violSrc  = regAddr[15:0];
        end

        // A detector still asserting wins over a clear in the same cycle
        if (s_q.faultSyncB) begin
            s_d.faultLatch = 1'b1;
        end

        // Events set sticky bits after any write-one clear
        if (violation) begin
            s_d.irqStat[IRQ_VIOL_BIT] = 1'b1;
        end
        if (faultRise) begin
            s_d.irqStat[IRQ_FAULT_BIT] = 1'b1;
        end
        s_d.irqLine = |(s_d.irqStat & s_d.irqMask);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // *************************************************************
    // Trim selection
    // *************************************************************
    trim_if trimBus ();

    assign trimBus.calWord   = s_q.cal;
    assign trimBus.flashLow  = flashTrimLow;
    assign trimBus.flashMid  = flashTrimMid;
    assign trimBus.flashHigh = flashTrimHigh;

    trim_select trimSel (
        .clk     (clk),
        .rst_n   (rst_n),
        .trimBus (trimBus)
    );

    // *************************************************************
    // Outputs
    // *************************************************************
    assign regRdata  = s_q.rdata;
    assign faultOut  = s_q.faultLatch;
    assign extWr     = s_q.extWr;
    assign extAddr   = s_q.extAddr;
    assign extWdata  = s_q.extWdata;
    assign trimLow   = trimBus.trimLow;
    assign trimMid   = trimBus.trimMid;
    assign trimHigh  = trimBus.trimHigh;
    assign protectOn = s_q.protEn;
    assign irq       = s_q.irqLine;

endmodule : clock_ctrl_write_protect

// *** core/clk_wp_pkg.sv ***
/*
 * Constants and types for the clock control write protection bank.
 * Assumes a 32-bit register port with byte addresses and one 100 MHz clock.
 */
package clk_wp_pkg;

    typedef logic [31:0] word_type;
    typedef logic [6:0]  trim_type;

    // *************************************************************
    // Register byte addresses
    // *************************************************************
    localparam word_type FAULT_CLEAR_ADDR   = 32'h400e0478;
    localparam word_type PROTECT_MODE_ADDR  = 32'h400e04e4;
    localparam word_type PROTECT_STAT_ADDR  = 32'h400e04e8;
    localparam word_type OSC_CAL_ADDR       = 32'h400e0510;
    localparam word_type MAIN_STATUS_ADDR   = 32'h400e0468;
    localparam word_type IRQ_STATUS_ADDR    = 32'h400e0520;
    localparam word_type IRQ_MASK_ADDR      = 32'h400e0524;
    localparam int       SHIELD_COUNT       = 10;
    localparam word_type SHIELD_ADDR [SHIELD_COUNT] = '{
        32'h400e0400, 32'h400e0404, 32'h400e0410, 32'h400e0414,
        32'h400e0420, 32'h400e0428, 32'h400e0430, 32'h400e0440,
        32'h400e0470, 32'h400e0474};

    // *************************************************************
    // Field positions
    // *************************************************************
    localparam int FAULT_CLEAR_BIT   = 0;
    localparam int PROTECT_EN_BIT    = 0;
    localparam int KEY_LSB           = 8;
    localparam logic [23:0] KEY_PASSWORD = 24'h504d43;
    localparam int VIOL_FLAG_BIT     = 0;
    localparam int VIOL_SRC_LSB      = 8;
    localparam int TRIM_LOW_LSB      = 0;
    localparam int TRIM_LOW_SEL      = 7;
    localparam int TRIM_MID_LSB      = 8;
    localparam int TRIM_MID_SEL      = 15;
    localparam int TRIM_HIGH_LSB     = 16;
    localparam int TRIM_HIGH_SEL     = 23;
    localparam int FAULT_STATE_BIT   = 20;
    localparam int IRQ_VIOL_BIT      = 0;
    localparam int IRQ_FAULT_BIT     = 1;
    localparam word_type CAL_MASK    = 32'h00ffffff;
    localparam logic [1:0] IRQ_MASK_BITS = 2'h3;

    // *************************************************************
    // Values after reset
    // *************************************************************
    localparam logic     PROTECT_RESET = 1'b0;
    localparam word_type CAL_RESET     = 32'h00000000;
    localparam trim_type TRIM_RESET    = 7'h00;

endpackage : clk_wp_pkg

// *** core/trim_if.sv ***
/*
 * Carrier between the register bank and the trim selector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface trim_if;
    import clk_wp_pkg::*;
    word_type calWord;
    trim_type flashLow;
    trim_type flashMid;
    trim_type flashHigh;
    trim_type trimLow;
    trim_type trimMid;
    trim_type trimHigh;
    modport source (output calWord, output flashLow, output flashMid,
                    output flashHigh, input trimLow, input trimMid, input trimHigh);
    modport sink   (input calWord, input flashLow, input flashMid,
                    input flashHigh, output trimLow, output trimMid, output trimHigh);
endinterface : trim_if

// *** core/trim_select.sv ***
/*
 * Chooses flash or user trim for each RC oscillator frequency.
 * Assumes flash trims are stable levels in the clk domain.
 */
`timescale 1ns/1ns
module trim_select (
    input  wire logic clk,
    input  wire logic rst_n,
    trim_if.sink      trimBus
);
    import clk_wp_pkg::*;

    typedef struct packed {
        trim_type low;
        trim_type mid;
        trim_type high;
    } trim_state_type;

    trim_state_type s_q;
    trim_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.low  = trimBus.calWord[TRIM_LOW_SEL]
                   ? trimBus.calWord[TRIM_LOW_LSB +: 7] : trimBus.flashLow;
        s_d.mid  = trimBus.calWord[TRIM_MID_SEL]
                   ? trimBus.calWord[TRIM_MID_LSB +: 7] : trimBus.flashMid;
        s_d.high = trimBus.calWord[TRIM_HIGH_SEL]
                   ? trimBus.calWord[TRIM_HIGH_LSB +: 7] : trimBus.flashHigh;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{low: TRIM_RESET, mid: TRIM_RESET, high: TRIM_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign trimBus.trimLow  = s_q.low;
    assign trimBus.trimMid  = s_q.mid;
    assign trimBus.trimHigh = s_q.high;

endmodule : trim_select

// *** bench/clock_ctrl_write_protect_assertions.sv ***
/*
 * Port checks for the clock control write protection bank.
 * Assumes one clock and the synchronous active-low reset of the block.
 */
`timescale 1ns/1ns
module clock_ctrl_write_protect_checker (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire clk_wp_pkg::word_type regAddr,
    input wire clk_wp_pkg::word_type regWdata,
    input wire logic                 regWr,
    input wire logic                 regRd,
    input wire clk_wp_pkg::word_type regRdata,
    input wire logic                 faultDetect,
    input wire logic                 faultOut,
    input wire logic                 extWr,
    input wire clk_wp_pkg::word_type extAddr,
    input wire clk_wp_pkg::word_type extWdata,
    input wire clk_wp_pkg::trim_type trimLow,
    input wire logic                 protectOn
);
    import clk_wp_pkg::*;
    // ***********************************************
    // Decode helpers
    // ***********************************************
    logic        isShield;
    logic [15:0] srcAddr;
    logic [6:0]  userLow;
    logic        wantOn, modeWr, keyOk, violWr, statRd;
    always_comb begin
        isShield = 1'b0;
        for (int i = 0; i < SHIELD_COUNT; i++) begin
            isShield = isShield | (regAddr == SHIELD_ADDR[i]);
        end
    end
    assign srcAddr = regAddr[15:0];
    assign userLow = regWdata[6:0];
    assign wantOn  = regWdata[PROTECT_EN_BIT];
    assign modeWr  = regWr && regAddr == PROTECT_MODE_ADDR;
    assign keyOk   = regWdata[31:8] == KEY_PASSWORD;
    assign violWr  = regWr && protectOn && (isShield || regAddr == OSC_CAL_ADDR);
    assign statRd  = regRd && regAddr == PROTECT_STAT_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_key_good_load:
    assert property (modeWr && keyOk |=> protectOn == $past(wantOn))
        else $error("protect enable did not follow keyed write");
    a_key_bad_hold:
    assert property (!(modeWr && keyOk) |=> $stable(protectOn))
        else $error("protect enable changed without key");
    a_mode_key_zero:
    assert property (regRd && regAddr == PROTECT_MODE_ADDR |=> regRdata == {31'h0, protectOn})
        else $error("protect mode read wrong");
    a_shield_block:
    assert property (violWr |=> !extWr)
        else $error("protected write was forwarded");
    a_shield_pass:
    assert property (regWr && !protectOn && isShield |=> extWr && extAddr == $past(regAddr)
        && extWdata == $past(regWdata)) else $error("open write not forwarded");
    a_viol_report:
    assert property (violWr ##1 statRd |=> regRdata == {8'h0, $past(srcAddr, 2), 7'h0, 1'b1})
        else $error("violation status wrong");
    a_stat_clear:
    assert property (statRd ##1 !regWr ##1 statRd |=> regRdata == 32'h0)
        else $error("status not cleared by read");
    a_trim_user:
    assert property (regWr && regAddr == OSC_CAL_ADDR && !protectOn && regWdata[TRIM_LOW_SEL]
        |-> ##2 trimLow == $past(userLow, 2)) else $error("user trim not applied");
    a_fault_clear:
    assert property ((!faultDetect) [*3] ##0 (regWr && regAddr == FAULT_CLEAR_ADDR
        && regWdata[0]) |=> !faultOut) else $error("fault output not cleared");
    a_fault_state:
    assert property (regRd && regAddr == MAIN_STATUS_ADDR
        |=> regRdata == {11'h0, $past(faultOut), 20'h0}) else $error("main status wrong");
    c_viol: cover property (violWr ##1 statRd);
    c_pass: cover property (extWr);
    c_fault: cover property ($rose(faultOut));
endmodule : clock_ctrl_write_protect_checker

bind clock_ctrl_write_protect clock_ctrl_write_protect_checker chk_u (
    .clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .faultDetect,
    .faultOut, .extWr, .extAddr, .extWdata, .trimLow, .protectOn);

// *** bench/clock_ctrl_write_protect_tb_top.sv ***
/*
 * Self-checking bench for the write protection bank with a register model.
 * Assumes the package is compiled first and the checker is bound in.
 */
`timescale 1ns/1ns
module clock_ctrl_write_protect_tb_top;
    import clk_wp_pkg::*;
    logic        clk, rst_n, regWr, regRd, faultDetect, faultOut, extWr, protectOn, irq;
    word_type    regAddr, regWdata, regRdata, extAddr, extWdata, mCal, d;
    trim_type    flashLow, flashMid, flashHigh, trimLow, trimMid, trimHigh;
    logic        mProt, mFlag;
    logic [15:0] mSrc;
    logic [1:0]  mIrqStat, mIrqMask;
    int          fails, n_tests;

    clock_ctrl_write_protect dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .faultDetect(faultDetect), .faultOut(faultOut), .extWr(extWr), .extAddr(extAddr),
        .extWdata(extWdata), .flashTrimLow(flashLow), .flashTrimMid(flashMid),
        .flashTrimHigh(flashHigh), .trimLow(trimLow), .trimMid(trimMid),
        .trimHigh(trimHigh), .protectOn(protectOn), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ***********************************************
    // Model and bus tasks
    // ***********************************************
    function automatic word_type stat();
        return {8'h0, mSrc, 7'h0, mFlag};
    endfunction : stat
    function automatic logic shielded(input word_type a);
        for (int i = 0; i < SHIELD_COUNT; i++) if (SHIELD_ADDR[i] == a) return 1'b1;
        return a == OSC_CAL_ADDR;
    endfunction : shielded
    task automatic chk(input string nm, input word_type seen, input word_type exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input word_type a, input word_type v);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge clk);
        regWr    <= 1'b0;
        if (mProt && shielded(a)) begin
            mFlag = 1'b1;
            mSrc = a[15:0];
            mIrqStat[0] = 1'b1;
        end else if (a == OSC_CAL_ADDR) mCal = v & CAL_MASK;
        if (a == PROTECT_MODE_ADDR && v[31:8] == KEY_PASSWORD) mProt = v[0];
        if (a == IRQ_STATUS_ADDR) mIrqStat = mIrqStat & ~v[1:0];
        if (a == IRQ_MASK_ADDR) mIrqMask = v[1:0];
    endtask : wr
    task automatic rd(input word_type a, input word_type e);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1 chk("regRdata", regRdata, e);
        if (a == PROTECT_STAT_ADDR) begin
            mFlag = 1'b0;
            mSrc = 16'h0;
        end
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        complete_run();
    end
    // ***********************************************
    // Test sequence
    // ***********************************************
    initial begin
        {rst_n, regWr, regRd, faultDetect, regAddr, regWdata} = '0;
        {mProt, mFlag, mSrc, mCal, mIrqStat, mIrqMask} = '0;
        void'($urandom(32'h6362));
        flashLow = 7'($urandom);
        flashMid = 7'($urandom);
        flashHigh = 7'($urandom);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("protectOn", word_type'(protectOn), 32'h0);
        rd(PROTECT_STAT_ADDR, 32'h0);
        rd(32'h400e0600, 32'h0);
        $display("test reset done");
        // Wrong key first, so a stuck-on enable shows up
        for (int i = 0; i < 4; i++) begin
            d = {i[0] ? KEY_PASSWORD : KEY_PASSWORD ^ 24'($urandom_range(1, 32'hffffff)),
                 7'($urandom), !i[1]};
            wr(PROTECT_MODE_ADDR, d);
            rd(PROTECT_MODE_ADDR, word_type'(mProt));
        end
        $display("test key done");
        for (int p = 0; p < 2; p++) begin
            wr(PROTECT_MODE_ADDR, {KEY_PASSWORD, 8'(p)});
            for (int i = 0; i < SHIELD_COUNT; i++) begin
                d = $urandom;
                wr(SHIELD_ADDR[i], d);
                #1 chk("extWr", word_type'(extWr), word_type'(!mProt));
                if (!mProt) chk("extAddr", extAddr, SHIELD_ADDR[i]);
                if (!mProt) chk("extWdata", extWdata, d);
                rd(PROTECT_STAT_ADDR, stat());
            end
        end
        rd(PROTECT_STAT_ADDR, stat());
        wr(OSC_CAL_ADDR, $urandom);
        rd(OSC_CAL_ADDR, mCal);
        rd(PROTECT_STAT_ADDR, stat());
        $display("test shield done");
        wr(PROTECT_MODE_ADDR, {KEY_PASSWORD, 8'h0});
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            {d[23], d[15], d[7]} = 3'(i);
            wr(OSC_CAL_ADDR, d);
            @(posedge clk);
            #1 chk("trimLow", word_type'(trimLow), word_type'(d[7] ? d[6:0] : flashLow));
            chk("trimMid", word_type'(trimMid), word_type'(d[15] ? d[14:8] : flashMid));
            chk("trimHigh", word_type'(trimHigh), word_type'(d[23] ? d[22:16] : flashHigh));
            rd(OSC_CAL_ADDR, mCal);
        end
        $display("test trim done");
        @(posedge clk) faultDetect <= 1'b1;
        repeat (4) @(posedge clk);
        mIrqStat[1] = 1'b1;
        rd(MAIN_STATUS_ADDR, 32'h1 << FAULT_STATE_BIT);
        @(posedge clk) faultDetect <= 1'b0;
        repeat (3) @(posedge clk);
        wr(FAULT_CLEAR_ADDR, 32'h1);
        #1 chk("faultOut", word_type'(faultOut), 32'h0);
        rd(MAIN_STATUS_ADDR, 32'h0);
        $display("test fault done");
        for (int m = 0; m < 5; m++) begin
            wr(m < 4 ? IRQ_MASK_ADDR : IRQ_STATUS_ADDR, m < 4 ? 32'(m) : 32'h3);
            @(posedge clk);
            #1 chk("irq", word_type'(irq), word_type'(|(mIrqStat & mIrqMask)));
            rd(IRQ_STATUS_ADDR, word_type'(mIrqStat));
        end
        $display("test irq done");
        complete_run();
    end
endmodule : clock_ctrl_write_protect_tb_top
